// >>> pkg/epc_pkg.sv
// What this block does
// - pwm mode, config 00: only output a modulated; b, c, d are port pins.
// - pwm mode, config 01: d modulated, a active, b and c inactive.
// - pwm mode, config 11: b modulated, c active, a and d inactive.
// - capture or compare mode: config ignored, pin a is ccp pin, others port.
// - output config field sits in control bits 7:6, used only in pwm mode.
// - duty low bits sit in control bits 5:4, unused outside pwm mode.
// - duty value is duty high byte followed by the two low bits.
// - mode field 0000 switches the unit off and resets it.
// - low mode bits pick polarity of pair a/c and pair b/d in pwm mode.
package epc_pkg;
	localparam logic [1:0] ADDR_CONTROL     = 2'h0;
	localparam logic [1:0] ADDR_DUTY_HIGH   = 2'h1;
	localparam logic [1:0] ADDR_PERIOD      = 2'h2;
	localparam logic [1:0] ADDR_STATUS      = 2'h3;
	localparam int         CFG_MSB          = 7;
	localparam int         CFG_LSB          = 6;
	localparam int         DLOW_MSB         = 5;
	localparam int         DLOW_LSB         = 4;
	localparam int         MODE_MSB         = 3;
	localparam int         MODE_LSB         = 0;
	localparam logic [7:0] CONTROL_RESET    = 8'h00;
	localparam logic [7:0] DUTY_HIGH_RESET  = 8'h00;
	localparam logic [7:0] PERIOD_RESET     = 8'hFF;
	localparam logic [3:0] MODE_OFF         = 4'h0;
	localparam logic [1:0] MODE_HI_PWM      = 2'h3;
	localparam logic [1:0] CFG_SINGLE       = 2'h0;
	localparam logic [1:0] CFG_FULL_FWD     = 2'h1;
	localparam logic [1:0] CFG_HALF         = 2'h2;
	localparam logic [1:0] CFG_FULL_REV     = 2'h3;
	localparam logic [7:0] DEAD_BAND_CYCLES = 8'h04;
endpackage

// >>> verilog/epc_pwm_core.sv
module epc_pwm_core
	import epc_pkg::*;
#(
	parameter int DUTY_W = 10
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              en_i,
	// control
	input  wire logic              run_i,
	input  wire logic [7:0]        period_i,
	input  wire logic [DUTY_W-1:0] duty_i,
	// waveform
	output logic                   pwm_o,
	output logic                   period_start_o
);
	logic [DUTY_W-1:0] cnt_ff;
	logic [DUTY_W-1:0] nxt_cnt;
	logic [DUTY_W-1:0] top;

	// counter runs in quarter steps so the two low bits matter
	assign top            = {period_i, 2'b11};
	assign nxt_cnt        = (cnt_ff == top) ? '0 : cnt_ff + 1'b1;
	assign period_start_o = run_i && (cnt_ff == '0);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= '0;
		end else if (en_i) begin
			cnt_ff <= run_i ? nxt_cnt : '0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_o <= 1'b0;
		end else if (en_i) begin
			pwm_o <= run_i && (nxt_cnt < duty_i);
		end
	end
endmodule

// >>> verilog/epc_dead_band.sv
module epc_dead_band
	import epc_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       en_i,
	// waveform in
	input  wire logic       pwm_i,
	input  wire logic [7:0] delay_i,
	// complementary out
	output logic            hi_o,
	output logic            lo_o
);
	logic       prev_ff;
	logic [7:0] wait_ff;

	// both sides idle while the delay runs, so switches never overlap
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_ff <= 1'b0;
			wait_ff <= 8'h00;
			hi_o    <= 1'b0;
			lo_o    <= 1'b0;
		end else if (en_i) begin
			prev_ff <= pwm_i;
			if (pwm_i != prev_ff) begin
				wait_ff <= delay_i;
				hi_o    <= 1'b0;
				lo_o    <= 1'b0;
			end else if (wait_ff > 8'h01) begin
				wait_ff <= wait_ff - 8'h01;
			end else begin
				// load cycle counts as the first idle cycle, so a zero delay still idles one
				wait_ff <= 8'h00;
				hi_o    <= pwm_i;
				lo_o    <= ~pwm_i;
			end
		end
	end
endmodule

// >>> verilog/epc_top.sv
module epc_top
	import epc_pkg::*;
(
	// clock, reset, enable
	input  wire logic       CLK_SYS_I,
	input  wire logic       RESET_I,
	input  wire logic       CE_I,
	// register port
	input  wire logic [1:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	output logic      [7:0] RDATA_O,
	// compare output from the capture/compare logic
	input  wire logic       CCP_OUT_I,
	// output pins
	output logic            PWM_OUT_A_O,
	output logic            PWM_OUT_B_O,
	output logic            PWM_OUT_C_O,
	output logic            PWM_OUT_D_O,
	// pin ownership, high while the unit owns the pin
	output logic            OWN_A_O,
	output logic            OWN_B_O,
	output logic            OWN_C_O,
	output logic            OWN_D_O
);
	logic [7:0] control_ff;
	logic [7:0] duty_high_ff;
	logic [7:0] period_ff;
	logic [7:0] duty_latch_ff;
	logic [1:0] duty_low_latch_ff;
	logic [1:0] output_config_field;
	logic [1:0] duty_low_bits;
	logic [3:0] unit_mode_field;
	logic       pwm_mode;
	logic       unit_off;
	logic       pwm_raw;
	logic       period_start;
	logic       half_hi;
	logic       half_lo;
	logic       pol_ac_low;
	logic       pol_bd_low;
	logic [9:0] duty_value;
	logic [3:0] nxt_pin;
	logic [3:0] nxt_own;
	logic [3:0] pin_ff;
	logic [3:0] own_ff;

	assign output_config_field = control_ff[CFG_MSB:CFG_LSB];
	assign duty_low_bits       = control_ff[DLOW_MSB:DLOW_LSB];
	assign unit_mode_field     = control_ff[MODE_MSB:MODE_LSB];
	assign pwm_mode            = unit_mode_field[3:2] == MODE_HI_PWM;
	assign unit_off            = unit_mode_field == MODE_OFF;
	assign pol_ac_low          = unit_mode_field[1];
	assign pol_bd_low          = unit_mode_field[0];

	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			control_ff <= CONTROL_RESET;
		end else if (CE_I && WR_I && ADDR_I == ADDR_CONTROL) begin
			control_ff <= WDATA_I;
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			duty_high_ff <= DUTY_HIGH_RESET;
			period_ff    <= PERIOD_RESET;
		end else if (CE_I && WR_I) begin
			if (ADDR_I == ADDR_DUTY_HIGH) begin
				duty_high_ff <= WDATA_I;
			end
			if (ADDR_I == ADDR_PERIOD) begin
				period_ff <= WDATA_I;
			end
		end
	end

	// duty is taken at period start so a cycle never sees half an update
	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			duty_latch_ff     <= DUTY_HIGH_RESET;
			duty_low_latch_ff <= 2'b00;
		end else if (CE_I) begin
			if (unit_off) begin
				duty_latch_ff     <= DUTY_HIGH_RESET;
				duty_low_latch_ff <= 2'b00;
			end else if (period_start || !pwm_mode) begin
				duty_latch_ff     <= duty_high_ff;
				duty_low_latch_ff <= duty_low_bits;
			end
		end
	end

	assign duty_value = {duty_latch_ff, duty_low_latch_ff};

	epc_pwm_core #(
		.DUTY_W (10)
	) u_core (
		.clk_i          (CLK_SYS_I),
		.rst_i          (RESET_I),
		.en_i           (CE_I),
		.run_i          (pwm_mode),
		.period_i       (period_ff),
		.duty_i         (duty_value),
		.pwm_o          (pwm_raw),
		.period_start_o (period_start)
	);

	epc_dead_band u_dead (
		.clk_i   (CLK_SYS_I),
		.rst_i   (RESET_I),
		.en_i    (CE_I),
		.pwm_i   (pwm_raw),
		.delay_i (DEAD_BAND_CYCLES),
		.hi_o    (half_hi),
		.lo_o    (half_lo)
	);

	// in pwm mode levels are active-sense first, then polarity, with the ownership mask applied last
	always_comb begin
		nxt_pin = 4'b0000;
		nxt_own = 4'b0000;
		if (unit_off) begin
			nxt_pin = 4'b0000;
			nxt_own = 4'b0000;
		end else if (!pwm_mode) begin
			nxt_pin = {3'b000, CCP_OUT_I};
			nxt_own = 4'b0001;
		end else begin
			case (output_config_field)
				CFG_SINGLE: begin
					nxt_pin = {3'b000, pwm_raw};
					nxt_own = 4'b0001;
				end
				CFG_FULL_FWD: begin
					nxt_pin = {pwm_raw, 1'b0, 1'b0, 1'b1};
					nxt_own = 4'b1111;
				end
				CFG_HALF: begin
					nxt_pin = {2'b00, half_lo, half_hi};
					nxt_own = 4'b0011;
				end
				CFG_FULL_REV: begin
					nxt_pin = {1'b0, 1'b1, pwm_raw, 1'b0};
					nxt_own = 4'b1111;
				end
				default: begin
					nxt_pin = 4'b0000;
					nxt_own = 4'b0000;
				end
			endcase
			nxt_pin = nxt_pin ^ {pol_bd_low, pol_ac_low, pol_bd_low, pol_ac_low};
			nxt_pin = nxt_pin & nxt_own;
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			pin_ff <= 4'b0000;
			own_ff <= 4'b0000;
		end else if (CE_I) begin
			pin_ff <= nxt_pin;
			own_ff <= nxt_own;
		end
	end

	assign PWM_OUT_A_O = pin_ff[0];
	assign PWM_OUT_B_O = pin_ff[1];
	assign PWM_OUT_C_O = pin_ff[2];
	assign PWM_OUT_D_O = pin_ff[3];
	assign OWN_A_O     = own_ff[0];
	assign OWN_B_O     = own_ff[1];
	assign OWN_C_O     = own_ff[2];
	assign OWN_D_O     = own_ff[3];

	// status shows live pin levels and ownership
	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			RDATA_O <= 8'h00;
		end else if (CE_I) begin
			if (RD_I) begin
				case (ADDR_I)
					ADDR_CONTROL:   RDATA_O <= control_ff;
					ADDR_DUTY_HIGH: RDATA_O <= duty_high_ff;
					ADDR_PERIOD:    RDATA_O <= period_ff;
					ADDR_STATUS:    RDATA_O <= {own_ff, pin_ff};
					default:        RDATA_O <= 8'h00;
				endcase
			end else begin
				RDATA_O <= 8'h00;
			end
		end
	end
endmodule

// >>> bench/epc_top_asserts.sv
module epc_top_asserts
	import epc_pkg::*;
(
	// clock, reset, writes
	input wire logic       CLK_SYS_I,
	input wire logic       RESET_I,
	input wire logic       CE_I,
	input wire logic [1:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic       WR_I,
	input wire logic       CCP_OUT_I,
	// pins
	input wire logic       PWM_OUT_A_O,
	input wire logic       PWM_OUT_B_O,
	input wire logic       PWM_OUT_C_O,
	input wire logic       PWM_OUT_D_O,
	input wire logic       OWN_A_O,
	input wire logic       OWN_B_O,
	input wire logic       OWN_C_O,
	input wire logic       OWN_D_O
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ctl_ff, ctl_d_ff;
	logic [3:0] own, pin;
	logic [1:0] cfg;
	logic       pwm, a_act, b_act;
	assign own   = {OWN_D_O, OWN_C_O, OWN_B_O, OWN_A_O};
	assign pin   = {PWM_OUT_D_O, PWM_OUT_C_O, PWM_OUT_B_O, PWM_OUT_A_O};
	assign cfg   = ctl_d_ff[7:6];
	assign pwm   = ctl_d_ff[3:2] == MODE_HI_PWM;
	assign a_act = PWM_OUT_A_O ^ ctl_d_ff[1];
	assign b_act = PWM_OUT_B_O ^ ctl_d_ff[0];
	// second stage matches the extra lag of the pin register
	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			ctl_ff   <= CONTROL_RESET;
			ctl_d_ff <= CONTROL_RESET;
		end else if (CE_I) begin
			if (WR_I && ADDR_I == ADDR_CONTROL) ctl_ff <= WDATA_I;
			ctl_d_ff <= ctl_ff;
		end
	end
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RESET_I);
	off_release_a:
		assert property (ctl_d_ff[3:0] == MODE_OFF |-> own == 4'h0 && pin == 4'h0)
		else $error("pins kept while off");
	ccp_pin_a:
		assert property ($past(CE_I) && !pwm && ctl_d_ff[3:0] != MODE_OFF
			|-> own == 4'h1 && PWM_OUT_A_O == $past(CCP_OUT_I)) else $error("ccp pin");
	single_own_a:
		assert property (pwm && cfg == CFG_SINGLE |-> own == 4'h1) else $error("single");
	fwd_held_a:
		assert property (pwm && cfg == CFG_FULL_FWD |-> own == 4'hF && a_act
			&& !b_act && PWM_OUT_C_O == ctl_d_ff[1]) else $error("forward");
	rev_held_a:
		assert property (pwm && cfg == CFG_FULL_REV |-> own == 4'hF && !a_act
			&& PWM_OUT_C_O != ctl_d_ff[1] && PWM_OUT_D_O == ctl_d_ff[0]) else $error("reverse");
	half_pair_a:
		assert property (pwm && cfg == CFG_HALF |-> own == 4'h3 && !(a_act && b_act))
		else $error("half");
	dead_band_a:
		assert property (pwm && cfg == CFG_HALF && $fell(a_act) |-> (!b_act)[*4])
		else $error("dead band");
	released_low_a:
		assert property ((pin & ~own) == 4'h0) else $error("unowned pin driven");
endmodule
bind epc_top epc_top_asserts u_epc_top_asserts (.CLK_SYS_I, .RESET_I, .CE_I, .ADDR_I,
	.WDATA_I, .WR_I, .CCP_OUT_I, .PWM_OUT_A_O, .PWM_OUT_B_O, .PWM_OUT_C_O, .PWM_OUT_D_O,
	.OWN_A_O, .OWN_B_O, .OWN_C_O, .OWN_D_O);

// >>> bench/epc_bridge_model.sv
module epc_bridge_model (
	// pins from the unit
	input  wire logic [3:0] pin_i,
	input  wire logic [3:0] own_i,
	// switch gate drive
	output logic      [3:0] gate_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// board pull-downs keep a released switch off
	assign gate_o = pin_i & own_i;
endmodule

// >>> bench/epc_top_test.sv
module epc_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import epc_pkg::*;
	logic       clk, rst, ce, wr, rd;
	logic       ccp = 1'b0;
	logic [1:0] addr;
	logic [7:0] wdata, rdata;
	logic [3:0] pin, own, gate;
	int         error_cnt, checks_done, cyc, c, m, n, k;
	logic [3:0] own_tab [4] = '{4'h1, 4'hF, 4'h3, 4'hF};
	int         mod_tab [4] = '{0, 3, 0, 1};
	epc_top u_epc_top (.CLK_SYS_I(clk), .RESET_I(rst), .CE_I(ce), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CCP_OUT_I(ccp),
		.PWM_OUT_A_O(pin[0]), .PWM_OUT_B_O(pin[1]), .PWM_OUT_C_O(pin[2]),
		.PWM_OUT_D_O(pin[3]), .OWN_A_O(own[0]), .OWN_B_O(own[1]), .OWN_C_O(own[2]),
		.OWN_D_O(own[3]));
	epc_bridge_model u_epc_bridge_model (.pin_i(pin), .own_i(own), .gate_o(gate));
	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", rdata, exp);
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// whole run is a few hundred cycles
	always @(posedge clk) begin
		cyc++;
		ccp <= ~ccp;
		if (cyc == 6000) begin
			error_cnt++;
			end_sim();
		end
	end
	initial begin
		{rst, ce, wr, rd, addr, wdata} = '0;
		rst = 1'b1;
		ce  = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd_reg(ADDR_CONTROL, CONTROL_RESET);
		rd_reg(ADDR_DUTY_HIGH, DUTY_HIGH_RESET);
		wr_reg(ADDR_CONTROL, 8'hF4);
		rd_reg(ADDR_CONTROL, 8'hF4);
		repeat (6) @(posedge clk);
		#1 chk("own capture", {4'h0, own}, 8'h01);
		ce <= 1'b0;
		wr_reg(ADDR_CONTROL, 8'h00);
		ce <= 1'b1;
		rd_reg(ADDR_CONTROL, 8'hF4);
		wr_reg(ADDR_CONTROL, 8'h00);
		wr_reg(ADDR_STATUS, 8'hFF);
		rd_reg(ADDR_STATUS, 8'h00);
		// short period so each case sees several cycles
		wr_reg(ADDR_PERIOD, 8'h01);
		wr_reg(ADDR_DUTY_HIGH, 8'h01);
		for (c = 0; c < 4; c++) begin
			for (m = 0; m < 4; m++) begin
				if (c == 2 && m != 0) continue;
				wr_reg(ADDR_CONTROL, {c[1:0], 2'b01, 2'b11, m[1:0]});
				repeat (24) @(posedge clk);
				#1 chk("own", {4'h0, own}, {4'h0, own_tab[c]});
				if (c == 1) chk("held", {4'h0, gate & 4'h7}, {5'h0, m[1], m[0], !m[1]});
				if (c == 3) chk("held", {4'h0, gate & 4'hD}, {4'h0, m[0], !m[1], 1'b0, m[1]});
				n = 0;
				for (k = 0; k < 8; k++) begin
					@(posedge clk);
					#1 n += int'(gate[mod_tab[c]] ^ (mod_tab[c] % 2 ? m[0] : m[1]));
				end
				if (c != 2) chk("duty", n[7:0], 8'h05);
			end
		end
		// longer period so both half-bridge sides outlast the dead band
		wr_reg(ADDR_PERIOD, 8'h03);
		wr_reg(ADDR_DUTY_HIGH, 8'h02);
		wr_reg(ADDR_CONTROL, 8'h9C);
		repeat (40) @(posedge clk);
		n = 0;
		c = 0;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			#1 n += int'(gate[0]);
			c += int'(gate[1]);
		end
		chk("half a", n[7:0], 8'h05);
		chk("half b", c[7:0], 8'h03);
		wr_reg(ADDR_CONTROL, 8'h00);
		repeat (3) @(posedge clk);
		#1 chk("own off", {4'h0, own}, 8'h00);
		end_sim();
	end
endmodule
